// *** design/cms_regs.vh ***
/*
 Sequencer constants: state codes, config field width, timing counts.
 Assumes the 40 MHz mclk; included by the sequencer modules.
*/
`ifndef CMS_REGS_VH
`define CMS_REGS_VH
// State codes
`define CMS_ST_OFF 3'h0
`define CMS_ST_IDLE 3'h1
`define CMS_ST_SAMPLE 3'h2
`define CMS_ST_HOLD 3'h3
`define CMS_ST_RUN 3'h4
`define CMS_ST_THERM 3'h5
`define CMS_ST_BOOT 3'h6
// Config code width (sixteen resistor settings)
`define CMS_CFG_W 4
`define CMS_CFG_RST 4'h0
// Clock period in ns
`define CMS_CLK_NS 25
// Power-on reset settle time in ns, and cycles rounded up
`define CMS_POR_NS 1000
`define CMS_POR_CYC ((`CMS_POR_NS + `CMS_CLK_NS - 1) / `CMS_CLK_NS)
// Consecutive equal reads needed to accept a config code
`define CMS_CFG_STABLE 4
`endif

// *** design/cms_seq.v ***
/*
 Operating-state sequencer of a buck-boost controller: off, idle checks,
 config sampling and hold, running with soft-start, thermal shutdown.
 Assumes analog comparators and the config reader drive pin-level inputs
 asynchronous to mclk; all of them pass through cms_sync first.
*/
`timescale 1ns/1ps
`include "cms_regs.vh"
module cms_seq #(
   parameter POR_CYC = `CMS_POR_CYC,
   parameter CFG_STABLE = `CMS_CFG_STABLE
) (
   input wire mclk, // 40 MHz clock
   input wire rst, // Synchronous reset, active high
   input wire ce, // Clock enable, freezes all state when low
   input wire en_above, // Enable pin above turn-on threshold
   input wire undervoltage_lockout_ok, // Undervoltage lockout input above threshold
   input wire vcc_ok, // Internal supply above lockout
   input wire checks_ok, // Startup checks passed
   input wire [3:0] cfg_code, // Resistor code from setting-select reader
   input wire cfg_valid, // Reader has a conversion result
   input wire therm_hot, // Junction over thermal shutdown limit (hysteretic)
   input wire boot_uv, // Bootstrap supply under its threshold (hysteretic)
   output reg logic_on, // Internal logic and reference powered
   output reg power_stage_en, // Power stage enable
   output reg soft_start, // Soft-start restart pulse, one cycle
   output reg [3:0] cfg_latched, // Latched configuration code
   output reg cfg_locked, // Configuration latched and held
   output reg [2:0] state_out // Current state code
);
   localparam ST_OFF = `CMS_ST_OFF;
   localparam ST_IDLE = `CMS_ST_IDLE;
   localparam ST_SAMPLE = `CMS_ST_SAMPLE;
   localparam ST_HOLD = `CMS_ST_HOLD;
   localparam ST_RUN = `CMS_ST_RUN;
   localparam ST_THERM = `CMS_ST_THERM;
   localparam ST_BOOT = `CMS_ST_BOOT;

   wire [10:0] sync_q;
   wire en_s;
   wire undervoltage_lockout_s;
   wire vcc_s;
   wire chk_s;
   wire cfgv_s;
   wire hot_s;
   wire buv_s;
   wire [3:0] code_s;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [15:0] por_cnt_reg;
   reg [3:0] stab_cnt_reg;
   reg [3:0] last_code_reg;
   reg [3:0] cfg_reg;
   reg lock_reg;
   wire por_done;
   wire code_stable;
   wire supply_ok;

   // All pin-level inputs cross into mclk before any logic reads them
   // Reset clears the chain to zero, the inactive level of every input
   cms_sync #(.W(11)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .d_in({en_above, undervoltage_lockout_ok, vcc_ok, checks_ok, cfg_valid, therm_hot, boot_uv,
         cfg_code}),
      .q_out(sync_q)
   );
   assign en_s = sync_q[10];
   assign undervoltage_lockout_s = sync_q[9];
   assign vcc_s = sync_q[8];
   assign chk_s = sync_q[7];
   assign cfgv_s = sync_q[6];
   assign hot_s = sync_q[5];
   assign buv_s = sync_q[4];
   assign code_s = sync_q[3:0];

   // Any of these falling drops the device back to shutdown and frees the config
   assign supply_ok = en_s & undervoltage_lockout_s & vcc_s;
   // Counter is sixteen bits, so settle counts above 65535 are cut short
   assign por_done = (por_cnt_reg >= POR_CYC[15:0]);
   // Code bits cross separately, so only accept after several equal reads
   assign code_stable = cfgv_s && (stab_cnt_reg >= CFG_STABLE[3:0]);

   // Next-state logic
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: begin
            if (supply_ok)
               state_next = ST_IDLE;
         end
         ST_IDLE: begin
            if (por_done && chk_s)
               state_next = ST_SAMPLE;
         end
         ST_SAMPLE: begin
            if (code_stable)
               state_next = ST_HOLD;
         end
         ST_HOLD: begin
            if (chk_s)
               state_next = ST_RUN;
         end
         ST_RUN: begin
            if (hot_s)
               state_next = ST_THERM;
            else if (buv_s)
               state_next = ST_BOOT;
         end
         ST_THERM: begin
            if (!hot_s)
               state_next = ST_RUN;
         end
         ST_BOOT: begin
            // auto restart on recovery
            // Heat outranks the bootstrap fault here, as it does in running
            if (hot_s)
               state_next = ST_THERM;
            else if (!buv_s)
               state_next = ST_RUN;
         end
         default: state_next = ST_OFF;
      endcase
      if (!supply_ok)
         state_next = ST_OFF;
   end

   // State register and power-on settle counter
   always @(posedge mclk) begin
      if (rst) begin
         state_reg <= `CMS_ST_OFF;
         por_cnt_reg <= 16'h0000;
      end else if (ce) begin
         state_reg <= state_next;
         if (state_reg == ST_OFF)
            por_cnt_reg <= 16'h0000;
         else if (!por_done)
            por_cnt_reg <= por_cnt_reg + 16'h0001;
      end
   end

   // Stability filter for the resistor code while sampling
   // A changing or invalid read restarts the count, so noise cannot latch a code
   always @(posedge mclk) begin
      if (rst) begin
         stab_cnt_reg <= 4'h0;
         last_code_reg <= `CMS_CFG_RST;
      end else if (ce) begin
         last_code_reg <= code_s;
         if (state_reg != ST_SAMPLE || !cfgv_s || code_s != last_code_reg)
            stab_cnt_reg <= 4'h0;
         else if (stab_cnt_reg < CFG_STABLE[3:0])
            stab_cnt_reg <= stab_cnt_reg + 4'h1;
      end
   end

   // Config latch: written once per power-up, cleared only by shutdown
   // Clear wins over latch: a code read while the supply falls is not kept
   always @(posedge mclk) begin
      if (rst) begin
         cfg_reg <= `CMS_CFG_RST;
         lock_reg <= 1'b0;
      end else if (ce) begin
         if (!supply_ok) begin
            cfg_reg <= `CMS_CFG_RST;
            lock_reg <= 1'b0;
         end else if (state_reg == ST_SAMPLE && code_stable && !lock_reg) begin
            cfg_reg <= code_s;
            lock_reg <= 1'b1;
         end
      end
   end

   // Registered outputs; the state-based ones use the next state so they align with it
   always @(posedge mclk) begin
      if (rst) begin
         logic_on <= 1'b0;
         power_stage_en <= 1'b0;
         soft_start <= 1'b0;
         cfg_latched <= `CMS_CFG_RST;
         cfg_locked <= 1'b0;
         state_out <= `CMS_ST_OFF;
      end else if (ce) begin
         logic_on <= (state_next != ST_OFF);
         power_stage_en <= (state_next == ST_RUN);
         soft_start <= (state_next == ST_RUN) && (state_reg != ST_RUN);
         // Config copies trail the latch by one edge; state_out does not
         cfg_latched <= cfg_reg;
         cfg_locked <= lock_reg;
         state_out <= state_next;
      end
   end
endmodule // cms_seq

// *** design/cms_sync.v ***
/*
 Two-flop synchroniser bank for pin-level inputs.
 Assumes inputs are asynchronous to mclk; first stage is read only by the second.
*/
`timescale 1ns/1ps
`include "cms_regs.vh"
module cms_sync #(
   parameter W = 1
) (
   input wire mclk, // System clock
   input wire rst, // Synchronous reset, active high
   input wire ce, // Clock enable
   input wire [W-1:0] d_in, // Asynchronous inputs
   output wire [W-1:0] q_out // Synchronised outputs
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;
   genvar i;
   // One pair of flops per bit
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         always @(posedge mclk) begin
            if (rst) begin
               meta_reg[i] <= 1'b0;
               sync_reg[i] <= 1'b0;
            end else if (ce) begin
               meta_reg[i] <= d_in[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
   assign q_out = sync_reg;
endmodule // cms_sync

// *** dv/cms_seq_monitor.sv ***
/* Checker for the sequencer's ports: state, power stage, soft-start, config.
   Assumes the cms_seq ports and the state codes of the shared header. */
`timescale 1ns/1ps
`include "cms_regs.vh"
module cms_seq_chk #(
   parameter POR_CYC = `CMS_POR_CYC,
   parameter CFG_STABLE = `CMS_CFG_STABLE
) (
   input wire mclk, // Clock
   input wire rst, // Reset
   input wire en_above, // Enable pin
   input wire undervoltage_lockout_ok, // Undervoltage input
   input wire vcc_ok, // Internal supply
   input wire therm_hot, // Thermal trip
   input wire boot_uv, // Bootstrap low
   input wire logic_on, // Logic powered
   input wire power_stage_en, // Stage enable
   input wire soft_start, // Ramp pulse
   input wire [3:0] cfg_latched, // Held code
   input wire cfg_locked, // Code held
   input wire [2:0] state_out // State code
);
   // One domain; reset silences every check
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Allow four edges: two sync stages plus one shared by state and output registers, and one spare
   wire sup_ok = en_above && undervoltage_lockout_ok && vcc_ok;
   wire is_run = state_out == `CMS_ST_RUN;
   a_off_quiet: assert property (
      state_out == `CMS_ST_OFF |-> !logic_on && !power_stage_en && !soft_start)
      else $error("Outputs active in shutdown");
   a_idle_first: assert property (
      $past(state_out) == `CMS_ST_OFF && state_out != `CMS_ST_OFF |-> state_out == `CMS_ST_IDLE)
      else $error("Left shutdown not into idle");
   a_stage_run: assert property (
      power_stage_en == is_run) else $error("Power stage outside running");
   a_ss_entry: assert property (
      is_run && !$past(is_run) |-> soft_start ##1 !soft_start)
      else $error("No single soft-start on entry");
   a_en_off: assert property (
      !en_above |-> ##[1:4] state_out == `CMS_ST_OFF) else $error("Enable low kept running");
   a_hot_trip: assert property (
      therm_hot && sup_ok && is_run |-> ##[1:4] state_out == `CMS_ST_THERM)
      else $error("Thermal trip missed");
   a_cold_back: assert property (
      state_out == `CMS_ST_THERM && !therm_hot && !boot_uv && sup_ok |-> ##[1:4] is_run)
      else $error("No return from thermal");
   a_boot_back: assert property (
      state_out == `CMS_ST_BOOT && !boot_uv && !therm_hot && sup_ok |-> ##[1:4] is_run)
      else $error("No return from bootstrap stop");
   a_cfg_held: assert property (
      cfg_locked && $past(cfg_locked) |-> cfg_latched == $past(cfg_latched))
      else $error("Held code changed");
   c_therm: cover property (state_out == `CMS_ST_THERM);
   c_boot: cover property (state_out == `CMS_ST_BOOT);
   c_ramp: cover property (soft_start);
endmodule // cms_seq_chk
bind cms_seq cms_seq_chk #(.POR_CYC(POR_CYC), .CFG_STABLE(CFG_STABLE)) u_chk (.mclk(mclk),
   .rst(rst), .en_above(en_above), .undervoltage_lockout_ok(undervoltage_lockout_ok), .vcc_ok(vcc_ok), .therm_hot(therm_hot),
   .boot_uv(boot_uv), .logic_on(logic_on), .power_stage_en(power_stage_en),
   .soft_start(soft_start), .cfg_latched(cfg_latched), .cfg_locked(cfg_locked),
   .state_out(state_out));

// *** dv/cms_seq_test.sv ***
/* Bench for the sequencer: shutdown, power-up, config hold, thermal and
   bootstrap recovery, supply loss. Assumes cms_seq and a 40 MHz clock. */
`timescale 1ns/1ps
`include "cms_regs.vh"
module cms_seq_test;
   localparam POR = 8; // Short settle count keeps the run brief
   reg mclk = 1'b0, rst = 1'b1, ce = 1'b1, chk = 1'b0, cv = 1'b0, hot = 1'b0, buv = 1'b0;
   reg [2:0] sup = 3'h0; // Enable, undervoltage, supply
   reg [3:0] code = 4'h0;
   wire lon, pse, ss, lck;
   wire [3:0] lat;
   wire [2:0] st;
   integer fails = 0, checks = 0, ss_n = 0;
   cms_seq #(.POR_CYC(POR), .CFG_STABLE(2)) u_dut (.mclk(mclk), .rst(rst), .ce(ce),
      .en_above(sup[2]), .undervoltage_lockout_ok(sup[1]), .vcc_ok(sup[0]), .checks_ok(chk), .cfg_code(code),
      .cfg_valid(cv), .therm_hot(hot), .boot_uv(buv), .logic_on(lon), .power_stage_en(pse),
      .soft_start(ss), .cfg_latched(lat), .cfg_locked(lck), .state_out(st));
   // 25 ns clock; ramp pulses counted as they come
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge ss) ss_n = ss_n + 1;
   task check(input string what, input [3:0] seen, input [3:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task step(input integer n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   // Bounded wait, since the sync pipeline delays every move
   task wait_st(input [2:0] s);
      integer i;
      for (i = 0; i < 200 && st !== s; i = i + 1) step(1);
      check("state", {1'b0, st}, {1'b0, s});
   endtask
   task t_off;
      chk = 1'b1;
      cv = 1'b1;
      hot = 1'b1;
      sup = 3'h3;
      step(10);
      check("state", {1'b0, st}, 4'h0);
      check("logic_on", {3'h0, lon}, 4'h0);
      chk = 1'b0;
      hot = 1'b0;
      $display("t_off done");
   endtask
   task t_up;
      code = 4'hA;
      sup = 3'h7;
      wait_st(`CMS_ST_IDLE);
      check("logic_on", {3'h0, lon}, 4'h1);
      step(POR + 20);
      check("state", {1'b0, st}, {1'b0, `CMS_ST_IDLE});
      chk = 1'b1;
      wait_st(`CMS_ST_SAMPLE);
      wait_st(`CMS_ST_RUN);
      check("latched", lat, 4'hA);
      check("locked", {3'h0, lck}, 4'h1);
      check("stage", {3'h0, pse}, 4'h1);
      check("ramps", ss_n[3:0], 4'h1);
      $display("t_up done");
   endtask
   task t_hold;
      code = 4'h5;
      step(20);
      check("latched", lat, 4'hA);
      // Clock enable low must hide a bootstrap fault that clears before it rises
      ce = 1'b0;
      buv = 1'b1;
      step(10);
      check("state", {1'b0, st}, {1'b0, `CMS_ST_RUN});
      check("stage", {3'h0, pse}, 4'h1);
      buv = 1'b0;
      step(1);
      ce = 1'b1;
      step(6);
      check("state", {1'b0, st}, {1'b0, `CMS_ST_RUN});
      check("ramps", ss_n[3:0], 4'h1);
      $display("t_hold done");
   endtask
   // Both faults stop the stage and come back with a new ramp
   task t_fault(input integer which);
      if (which == 0) hot = 1'b1;
      else buv = 1'b1;
      wait_st(which == 0 ? `CMS_ST_THERM : `CMS_ST_BOOT);
      check("stage", {3'h0, pse}, 4'h0);
      hot = 1'b0;
      buv = 1'b0;
      wait_st(`CMS_ST_RUN);
      check("ramps", ss_n[3:0], 4'h2 + which[3:0]);
      $display("t_fault done");
   endtask
   // Each supply input in turn drops, unlocks and relatches the new code
   task t_drop;
      integer k;
      for (k = 0; k < 3; k = k + 1) begin
         sup = 3'h7 ^ (3'h1 << k);
         wait_st(`CMS_ST_OFF);
         // Lock output trails the state by one edge
         step(1);
         check("locked", {3'h0, lck}, 4'h0);
         if (k == 0) cv = 1'b0;
         sup = 3'h7;
         // First pass: no valid read keeps the sequencer sampling
         if (k == 0) begin
            wait_st(`CMS_ST_SAMPLE);
            step(10);
            check("state", {1'b0, st}, {1'b0, `CMS_ST_SAMPLE});
            cv = 1'b1;
         end
         wait_st(`CMS_ST_RUN);
         check("latched", lat, 4'h5);
      end
      $display("t_drop done");
   endtask
   task close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      step(12);
      rst = 1'b0;
      t_off;
      t_up;
      t_hold;
      t_fault(0);
      t_fault(1);
      t_drop;
      close_out;
   end
   // Whole run needs well under 2000 cycles
   initial begin
      #100000;
      fails = fails + 1;
      close_out;
   end
endmodule // cms_seq_test
